// ==== hdl/tdsr_dev.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - early variant: flag follows tone, no guard
// - controller applies software guard on early flag
// - validated flag rises only after guard time
// - sixteen tone pairs map to distinct codes
// - four pulses after flag shift digit out
// - first pulse rise latches whole digit
// - output pin shared with call progress cadence
// - power down holds serial output low
// - power down holds both flags low
// - high power-down input enters low power
// - power-down input pulled down internally
// - shift pulse idles low, pulled down internally
// - shift pulse held low during power down
// - first rise gives lsb, then ascending bits
// - partial readout blocks new digit capture
// - pulses past fourth ignored until flag rises
// - digit bits from first rise to fourth fall
module tdsr_dev
  import tdsr_pkg::*;
#(
  parameter bit VALIDATED_VARIANT = 1'b0
)
(
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic tone_present,
  input wire logic [1:0] low_group,
  input wire logic [1:0] high_group,
  input wire logic call_progress,
  output logic powered_down,
  tdsr_if.dev link
);

  typedef enum logic [1:0] {TDSR_IDLE, TDSR_ARMED, TDSR_SHIFT} tdsr_dev_e;

  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_s3_ff;
  logic pd_s1_ff;
  logic pd_s2_ff;
  logic ack_pin;
  logic pd_pin;
  logic ack_rise;
  logic ack_fall;
  logic [3:0] digit_ff;
  logic early_ff;
  logic val_ff;
  logic [8:0] guard_cnt_ff;
  logic steer;
  logic steer_d_ff;
  logic steer_rise;
  tdsr_dev_e state_ff;
  tdsr_dev_e nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [3:0] shreg_ff;
  logic [3:0] nxt_shreg;
  logic pend_ff;
  logic nxt_pend;
  logic sout_ff;
  logic nxt_sout;

  // an undriven pin reads low, as the internal pull-downs make it
  // pull-down on power-down
  assign pd_pin = link.power_down_oe & link.power_down_in;
  assign ack_pin = link.shift_pulse_oe & link.shift_pulse;

  // pins come from the controller's clock, so two flops first
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      pd_s1_ff <= 1'b0;
      pd_s2_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= ack_pin;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      pd_s1_ff <= pd_pin;
      pd_s2_ff <= pd_s1_ff;
    end
  end

  // edges are taken from the second and third stages only
  assign ack_rise = ack_s2_ff & ~ack_s3_ff;
  assign ack_fall = ~ack_s2_ff & ack_s3_ff;

  assign powered_down = pd_s2_ff;

  // decoded digit follows the detector while a tone is present and power down is off
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      digit_ff <= DIGIT_RST;
    else if (tone_present && !pd_s2_ff)
      digit_ff <= tdsr_decode(low_group, high_group);
  end

  // early flag: no validation, just presence
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      early_ff <= 1'b0;
    else
      early_ff <= tone_present & ~pd_s2_ff;
  end

  // validated flag: tone must persist for the on guard, and be
  // absent for the off guard before it drops, so dropouts are bridged
  always_ff @(posedge link_clk)
  begin
    if (link_rst || pd_s2_ff)
    begin
      val_ff <= 1'b0;
      guard_cnt_ff <= 9'h000;
    end
    else if (val_ff == tone_present)
      guard_cnt_ff <= 9'h000;
    else if (!val_ff && guard_cnt_ff == GUARD_ON_CYC - 9'h001)
    begin
      val_ff <= 1'b1;
      guard_cnt_ff <= 9'h000;
    end
    else if (val_ff && guard_cnt_ff == GUARD_OFF_CYC - 9'h001)
    begin
      val_ff <= 1'b0;
      guard_cnt_ff <= 9'h000;
    end
    else
      guard_cnt_ff <= guard_cnt_ff + 9'h001;
  end

  // the steering flag of the built variant arms the readout
  assign steer = VALIDATED_VARIANT ? val_ff : early_ff;

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      steer_d_ff <= 1'b0;
    else
      steer_d_ff <= steer;
  end

  assign steer_rise = steer & ~steer_d_ff;

  // readout sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shreg = shreg_ff;
    nxt_pend = pend_ff;
    unique case (state_ff)
      TDSR_IDLE:
      begin
        if (steer_rise)
          nxt_state = TDSR_ARMED;
      end
      TDSR_ARMED:
      begin
        if (ack_rise)
        begin
          nxt_shreg = digit_ff;
          nxt_cnt = 3'h1;
          nxt_state = TDSR_SHIFT;
        end
      end
      TDSR_SHIFT:
      begin
        if (steer_rise)
          nxt_pend = 1'b1;
        if (ack_rise && cnt_ff != SHIFT_PULSES)
        begin
          nxt_shreg = {1'b0, shreg_ff[3:1]};
          nxt_cnt = cnt_ff + 3'h1;
        end
        else if (ack_fall && cnt_ff == SHIFT_PULSES)
        begin
          // back to cadence on fourth fall
          nxt_cnt = 3'h0;
          nxt_pend = 1'b0;
          nxt_state = (pend_ff || steer_rise) ? TDSR_ARMED : TDSR_IDLE;
        end
      end
    endcase
  end

  // power down abandons any readout; the controller is expected to
  // keep the shift pulse low then, so nothing is lost in practice
  always_ff @(posedge link_clk)
  begin
    if (link_rst || pd_s2_ff)
    begin
      state_ff <= TDSR_IDLE;
      cnt_ff <= 3'h0;
      shreg_ff <= DIGIT_RST;
      pend_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shreg_ff <= nxt_shreg;
      pend_ff <= nxt_pend;
    end
  end

  // pin mux: low in power down, digit bit while shifting, cadence otherwise
  always_comb
  begin
    if (pd_s2_ff)
      nxt_sout = 1'b0;
    else if (nxt_state == TDSR_SHIFT)
      nxt_sout = nxt_shreg[0];
    else
      nxt_sout = call_progress;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      sout_ff <= 1'b0;
    else
      sout_ff <= nxt_sout;
  end

  // only the flag of the built variant exists; the other stays low
  assign link.early_tone_flag = VALIDATED_VARIANT ? 1'b0 : early_ff;
  assign link.validated_digit_flag = VALIDATED_VARIANT ? val_ff : 1'b0;
  assign link.serial_cadence_out = sout_ff;

endmodule : tdsr_dev

// ==== hdl/tdsr_host.sv ====
`timescale 1ns/1ps
module tdsr_host
  import tdsr_pkg::*;
#(
  parameter bit USE_SW_GUARD = 1'b1,
  parameter int SW_GUARD_CYC = SW_GUARD_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic power_down_req,
  output logic [3:0] digit,
  output logic digit_valid,
  output logic cadence,
  output logic steer_seen,
  output logic busy,
  tdsr_if.host link
);

  typedef enum logic [1:0] {TDSR_H_IDLE, TDSR_H_GUARD, TDSR_H_HIGH,
                            TDSR_H_LOW} tdsr_host_e;

  logic st_s1_ff;
  logic st_s2_ff;
  logic st_s3_ff;
  logic sd_s1_ff;
  logic sd_s2_ff;
  logic steer_rise;
  tdsr_host_e state_ff;
  logic [15:0] guard_cnt_ff;
  logic [7:0] half_cnt_ff;
  logic [1:0] bit_cnt_ff;
  logic [3:0] digit_ff;
  logic valid_ff;
  logic ack_ff;
  logic pd_ff;
  logic cad_ff;

  // device pins arrive from the link clock domain
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_s1_ff <= 1'b0;
      st_s2_ff <= 1'b0;
      st_s3_ff <= 1'b0;
      sd_s1_ff <= 1'b0;
      sd_s2_ff <= 1'b0;
    end
    else
    begin
      st_s1_ff <= link.early_tone_flag | link.validated_digit_flag;
      st_s2_ff <= st_s1_ff;
      st_s3_ff <= st_s2_ff;
      sd_s1_ff <= link.serial_cadence_out;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  assign steer_rise = st_s2_ff & ~st_s3_ff;

  // readout: optional guard, then four slow pulses sampled at the
  // end of each high phase, long enough for the device's syncs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= TDSR_H_IDLE;
      guard_cnt_ff <= 16'h0000;
      half_cnt_ff <= 8'h00;
      bit_cnt_ff <= 2'h0;
      digit_ff <= DIGIT_RST;
      valid_ff <= 1'b0;
      ack_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      unique case (state_ff)
        TDSR_H_IDLE:
        begin
          guard_cnt_ff <= 16'h0000;
          // a power-down request taken at this edge wins over the flag,
          // else pulses would start while the pin goes high
          if (steer_rise && !pd_ff && !power_down_req)
            state_ff <= TDSR_H_GUARD;
        end
        TDSR_H_GUARD:
        begin
          if (!st_s2_ff)
            state_ff <= TDSR_H_IDLE;
          else if (!USE_SW_GUARD ||
                   guard_cnt_ff == 16'(SW_GUARD_CYC - 1))
          begin
            state_ff <= TDSR_H_HIGH;
            half_cnt_ff <= 8'h00;
            bit_cnt_ff <= 2'h0;
            ack_ff <= 1'b1;
          end
          else
            guard_cnt_ff <= guard_cnt_ff + 16'h0001;
        end
        TDSR_H_HIGH:
        begin
          if (half_cnt_ff == SHIFT_HALF_CYC - 8'h01)
          begin
            // lsb arrives first
            digit_ff <= {sd_s2_ff, digit_ff[3:1]};
            half_cnt_ff <= 8'h00;
            ack_ff <= 1'b0;
            state_ff <= TDSR_H_LOW;
          end
          else
            half_cnt_ff <= half_cnt_ff + 8'h01;
        end
        TDSR_H_LOW:
        begin
          if (half_cnt_ff != SHIFT_HALF_CYC - 8'h01)
            half_cnt_ff <= half_cnt_ff + 8'h01;
          else if (bit_cnt_ff == 2'h3)
          begin
            valid_ff <= 1'b1;
            state_ff <= TDSR_H_IDLE;
          end
          else
          begin
            half_cnt_ff <= 8'h00;
            bit_cnt_ff <= bit_cnt_ff + 2'h1;
            ack_ff <= 1'b1;
            state_ff <= TDSR_H_HIGH;
          end
        end
      endcase
    end
  end

  // power down only changes when idle, so the pulse is low then
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pd_ff <= 1'b0;
    else if (state_ff == TDSR_H_IDLE)
      pd_ff <= power_down_req;
  end

  // cadence is only meaningful outside a readout
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cad_ff <= 1'b0;
    else if (state_ff == TDSR_H_IDLE || state_ff == TDSR_H_GUARD)
      cad_ff <= sd_s2_ff;
  end

  assign link.shift_pulse = ack_ff;
  assign link.shift_pulse_oe = 1'b1;
  assign link.power_down_in = pd_ff;
  assign link.power_down_oe = 1'b1;

  assign digit = digit_ff;
  assign digit_valid = valid_ff;
  assign cadence = cad_ff;
  assign steer_seen = st_s2_ff;
  assign busy = (state_ff != TDSR_H_IDLE);

endmodule : tdsr_host

// ==== hdl/tdsr_if.sv ====
`timescale 1ns/1ps
// pins between the tone receiver and its controller
interface tdsr_if;
  logic early_tone_flag;
  logic validated_digit_flag;
  logic serial_cadence_out;
  logic shift_pulse;
  logic shift_pulse_oe;
  logic power_down_in;
  logic power_down_oe;

  modport dev (
    output early_tone_flag,
    output validated_digit_flag,
    output serial_cadence_out,
    input shift_pulse,
    input shift_pulse_oe,
    input power_down_in,
    input power_down_oe
  );

  modport host (
    input early_tone_flag,
    input validated_digit_flag,
    input serial_cadence_out,
    output shift_pulse,
    output shift_pulse_oe,
    output power_down_in,
    output power_down_oe
  );
endinterface : tdsr_if

// ==== hdl/tdsr_pkg.sv ====
package tdsr_pkg;

  // clock periods of the two domains
  localparam int SYS_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 80;

  // decoded digit width and pulses per readout
  localparam int DIGIT_W = 4;
  localparam logic [2:0] SHIFT_PULSES = 3'h4;
  localparam logic [3:0] DIGIT_RST = 4'h0;

  // internal guard times of the validated variant, link clock cycles
  localparam int GUARD_ON_NS = 20000;
  localparam int GUARD_OFF_NS = 20000;
  localparam logic [8:0] GUARD_ON_CYC =
    9'((GUARD_ON_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [8:0] GUARD_OFF_CYC =
    9'((GUARD_OFF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

  // software guard time of the controller, sys_clk cycles (> 4096)
  localparam int SW_GUARD_NS = 40000;
  localparam int SW_GUARD_CYC_DEF =
    (SW_GUARD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // half period of one shift pulse, sys_clk cycles
  localparam int SHIFT_HALF_NS = 800;
  localparam logic [7:0] SHIFT_HALF_CYC =
    8'((SHIFT_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  // tone pair to digit code, index = {low group row, high group column}
  function automatic logic [3:0] tdsr_decode(input logic [1:0] row,
                                             input logic [1:0] col);
    logic [3:0] code;
    code = 4'h0;
    unique case ({row, col})
      4'h0: code = 4'h1;
      4'h1: code = 4'h2;
      4'h2: code = 4'h3;
      4'h3: code = 4'hd;
      4'h4: code = 4'h4;
      4'h5: code = 4'h5;
      4'h6: code = 4'h6;
      4'h7: code = 4'he;
      4'h8: code = 4'h7;
      4'h9: code = 4'h8;
      4'ha: code = 4'h9;
      4'hb: code = 4'hf;
      4'hc: code = 4'hb;
      4'hd: code = 4'ha;
      4'he: code = 4'hc;
      4'hf: code = 4'h0;
    endcase
    return code;
  endfunction : tdsr_decode

endpackage : tdsr_pkg

// ==== sim/tdsr_props.sv ====
`timescale 1ns/1ps
// pin checks in both clock domains
module tdsr_props #(
  parameter bit VALIDATED_VARIANT = 1'b0
)
(
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic early_tone_flag,
  input wire logic validated_digit_flag,
  input wire logic serial_cadence_out,
  input wire logic shift_pulse,
  input wire logic power_down_in
);
  logic [2:0] pulse_cnt_ff;

  // pulses since the early flag rose; saturates so a runaway host stays visible
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || $rose(early_tone_flag))
      pulse_cnt_ff <= 3'h0;
    else if ($rose(shift_pulse) && pulse_cnt_ff != 3'h7)
      pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
  end

  // six edges leave room for the two-flop sync
  property p_pd_sout;
    @(posedge link_clk) disable iff (link_rst)
    power_down_in [*6] |-> !serial_cadence_out;
  endproperty
  a_pd_sout: assert property (p_pd_sout)
    else $error("serial pin active in power down");

  property p_pd_flag;
    @(posedge link_clk) disable iff (link_rst)
    power_down_in [*6] |-> !early_tone_flag && !validated_digit_flag;
  endproperty
  a_pd_flag: assert property (p_pd_flag)
    else $error("flag high in power down");

  property p_no_vflag;
    @(posedge link_clk) disable iff (link_rst)
    !VALIDATED_VARIANT |-> !validated_digit_flag;
  endproperty
  a_no_vflag: assert property (p_no_vflag)
    else $error("validated flag in early variant");

  property p_pd_nopulse;
    @(posedge sys_clk) disable iff (sys_rst)
    power_down_in |-> !shift_pulse;
  endproperty
  a_pd_nopulse: assert property (p_pd_nopulse)
    else $error("shift pulse during power down");

  property p_pulse_hi;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(shift_pulse) |-> shift_pulse [*8];
  endproperty
  a_pulse_hi: assert property (p_pulse_hi)
    else $error("shift pulse high phase too short");

  property p_pulse_lo;
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(shift_pulse) |-> !shift_pulse [*8];
  endproperty
  a_pulse_lo: assert property (p_pulse_lo)
    else $error("shift pulse low phase too short");

  property p_pulse_guard;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(shift_pulse) && pulse_cnt_ff == 3'h0 |-> $past(early_tone_flag, 40);
  endproperty
  a_pulse_guard: assert property (p_pulse_guard)
    else $error("first pulse before guard time");

  property p_pulse_cnt;
    @(posedge sys_clk) disable iff (sys_rst)
    pulse_cnt_ff <= 3'h4;
  endproperty
  a_pulse_cnt: assert property (p_pulse_cnt)
    else $error("more than four pulses per flag");
endmodule : tdsr_props

// ==== sim/tone_digit_serial_readout_tb_top.sv ====
`timescale 1ns/1ps
module tone_digit_serial_readout_tb_top;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst, link_rst, tone_present, call_progress, power_down_req;
  logic [1:0] low_group, high_group;
  logic [3:0] digit, wire_bits;
  logic digit_valid, cadence, steer_seen, busy, powered_down;
  logic [3:0] digit_v;
  logic digit_valid_v;
  int error_cnt = 0;
  int n_tests = 0;
  int n_valid = 0;
  int n_cycles = 0;
  int v;
  localparam logic [3:0] EXP_CODE [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4,
    4'h5, 4'h6, 4'he, 4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};

  tdsr_if lk();
  tdsr_if lk_v();
  tdsr_dev #(.VALIDATED_VARIANT(1'b0)) i_tdsr_dev (.link_clk(link_clk),
    .link_rst(link_rst), .tone_present(tone_present),
    .low_group(low_group), .high_group(high_group),
    .call_progress(call_progress), .powered_down(powered_down), .link(lk));
  // short software guard keeps the run brief
  tdsr_host #(.USE_SW_GUARD(1'b1), .SW_GUARD_CYC(50)) i_tdsr_host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .power_down_req(power_down_req),
    .digit(digit), .digit_valid(digit_valid), .cadence(cadence),
    .steer_seen(steer_seen), .busy(busy), .link(lk));
  tdsr_props #(.VALIDATED_VARIANT(1'b0)) i_tdsr_props (.link_clk(link_clk),
    .link_rst(link_rst), .sys_clk(sys_clk), .sys_rst(sys_rst),
    .early_tone_flag(lk.early_tone_flag),
    .validated_digit_flag(lk.validated_digit_flag),
    .serial_cadence_out(lk.serial_cadence_out),
    .shift_pulse(lk.shift_pulse), .power_down_in(lk.power_down_in));

  // validated variant pair: the device guards, the host reads at once
  if (1)
  begin : g_val
    tdsr_dev #(.VALIDATED_VARIANT(1'b1)) i_tdsr_dev (.link_clk(link_clk),
      .link_rst(link_rst), .tone_present(tone_present),
      .low_group(low_group), .high_group(high_group),
      .call_progress(call_progress), .powered_down(), .link(lk_v));
    tdsr_host #(.USE_SW_GUARD(1'b0), .SW_GUARD_CYC(50)) i_tdsr_host (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .power_down_req(power_down_req),
      .digit(digit_v), .digit_valid(digit_valid_v), .cadence(),
      .steer_seen(), .busy(), .link(lk_v));
  end

  // link edges fall on sys falling edges, never on its sampling edge
  always #4 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;

  // wire bits sampled as each pulse falls, newest at the top
  always @(negedge lk.shift_pulse)
    wire_bits = {lk.serial_cadence_out, wire_bits[3:1]};

  // completion count and hang limit, sampled off the launching edge
  always @(negedge sys_clk)
  begin
    n_cycles++;
    if (digit_valid === 1'b1)
      n_valid++;
    if (n_cycles == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk_bit

  task automatic chk_digit(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: digit %h not %h", $time, got, exp);
    end
  endtask : chk_digit

  task automatic link_wait(input int n);
    repeat (n) @(negedge link_clk);
  endtask : link_wait

  task automatic tone(input logic [1:0] r, input logic [1:0] c,
                      input logic on);
    @(negedge link_clk);
    low_group = r;
    high_group = c;
    tone_present = on;
  endtask : tone

  // bounded wait for the host to finish a readout
  task automatic wait_dv(input bit val);
    int k;
    logic dv;
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
      dv = val ? digit_valid_v : digit_valid;
    end
    while (dv !== 1'b1 && k < 3000);
    chk_bit(dv, 1'b1, "no digit read");
  endtask : wait_dv

  task automatic read_digit(input logic [3:0] i);
    tone(i[3:2], i[1:0], 1'b1);
    link_wait(2);
    chk_bit(lk.early_tone_flag, 1'b1, "flag low on tone");
    chk_bit(lk.validated_digit_flag, 1'b0, "validated flag");
    wait_dv(1'b0);
    chk_digit(digit, EXP_CODE[i]);
    chk_digit(wire_bits, EXP_CODE[i]);
    tone(i[3:2], i[1:0], 1'b0);
    link_wait(6);
    chk_bit(lk.early_tone_flag, 1'b0, "flag high, no tone");
    chk_bit(lk.serial_cadence_out, call_progress, "pin");
    chk_bit(cadence, call_progress, "cadence");
  endtask : read_digit

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    {sys_rst, link_rst} = 2'h3;
    {tone_present, call_progress} = 2'h0;
    {low_group, high_group, power_down_req} = 5'h00;
    wire_bits = 4'h0;
    // ten sys cycles span a link edge, and the syncs reset with it
    repeat (10) @(negedge sys_clk);
    {sys_rst, link_rst} = 2'h0;
    // every tone pair, cadence level alternating
    for (int i = 0; i < 16; i++)
    begin
      call_progress = i[0];
      read_digit(4'(i));
    end
    $display("test digits done");
    // tone shorter than the software guard is dropped
    v = n_valid;
    tone(2'h0, 2'h0, 1'b1);
    tone(2'h0, 2'h0, 1'b0);
    link_wait(100);
    chk_bit(n_valid == v, 1'b1, "short tone read");
    $display("test guard done");
    // digit changes after the first pulse rise
    tone(2'h1, 2'h1, 1'b1);
    @(posedge lk.shift_pulse);
    link_wait(4);
    tone(2'h3, 2'h3, 1'b1);
    wait_dv(1'b0);
    chk_digit(digit, 4'h5);
    tone(2'h3, 2'h3, 1'b0);
    link_wait(6);
    $display("test capture done");
    // power down with cadence high and a tone arriving
    v = n_valid;
    call_progress = 1'b1;
    @(negedge sys_clk);
    power_down_req = 1'b1;
    link_wait(10);
    chk_bit(lk.serial_cadence_out, 1'b0, "pin in power down");
    chk_bit(powered_down, 1'b1, "not powered down");
    tone(2'h2, 2'h1, 1'b1);
    link_wait(20);
    chk_bit(lk.early_tone_flag, 1'b0, "flag in power down");
    chk_bit(n_valid == v, 1'b1, "read in power down");
    @(negedge sys_clk);
    power_down_req = 1'b0;
    wait_dv(1'b0);
    chk_digit(digit, EXP_CODE[9]);
    tone(2'h2, 2'h1, 1'b0);
    link_wait(6);
    $display("test power down done");
    // validated flag waits out the on guard, then its host reads
    tone(2'h3, 2'h1, 1'b1);
    link_wait(245);
    chk_bit(lk_v.validated_digit_flag, 1'b0, "early validation");
    link_wait(10);
    chk_bit(lk_v.validated_digit_flag, 1'b1, "no validation");
    chk_bit(lk_v.early_tone_flag, 1'b0, "early flag in variant");
    wait_dv(1'b1);
    chk_digit(digit_v, EXP_CODE[13]);
    tone(2'h3, 2'h1, 1'b0);
    link_wait(6);
    $display("test validated done");
    conclude();
  end
endmodule : tone_digit_serial_readout_tb_top
